// [hdl/deep_sleep_pkg.sv]
// Constants, field layouts and types shared by the deep-sleep control logic.
package deep_sleep_pkg;

  // ------------------------------------------------------------------
  // Register map (management register numbers).
  // ------------------------------------------------------------------
  localparam logic [4:0]  ADDR_AFE_ZERO  = 5'h11;  // Front-end control zero.
  localparam logic [4:0]  ADDR_AFE_TWO   = 5'h13;  // Front-end control two.
  localparam logic [4:0]  ADDR_AFE_THREE = 5'h14;  // Front-end control three.

  // Reset values of the three registers.
  localparam logic [15:0] AFE_ZERO_RST  = 16'h0000;
  localparam logic [15:0] AFE_TWO_RST   = 16'h0000;
  localparam logic [15:0] AFE_THREE_RST = 16'h0000;

  // ------------------------------------------------------------------
  // Field positions.
  // ------------------------------------------------------------------
  localparam int          PD_SLOW_OSC_BIT  = 6;   // Power-down slow oscillator.
  localparam int          DET_THRESH_BIT   = 15;  // Pulse detector threshold.
  localparam int          UDS_SLOW_OSC_BIT = 0;   // Deepest-standby slow oscillator.
  // Bits of register 13h that have a non-volatile copy: [9:8] and [1:0].
  localparam logic [15:0] AFE_TWO_NV_MASK  = 16'h0303;

  // Layout of front-end control three.
  typedef struct packed {
    logic [8:0] reserved;          // Bits 15:7, read/write, default zero.
    logic       method_manual;     // 1 = host-commanded, 0 = automatic.
    logic       manual_sleep;      // 1 = enter deepest standby.
    logic       nonvolatile_shadow_enable; // 1 = use the retained copy.
    logic       sleep_enable;      // 1 = deepest standby permitted.
    logic       rx_term_disable;   // 1 = receive termination off.
    logic       long_loss_delay;   // 1 = increased energy-loss delay.
    logic       indication_low;    // 1 = energy indication active low.
  } afe_three_t;

  // ------------------------------------------------------------------
  // Timing.
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 20;     // 50 MHz system clock.
  localparam int LOSS_SHORT_NS      = 2000;   // Minimum energy-loss delay.
  localparam int LOSS_LONG_NS       = 50000;  // Increased energy-loss delay.
  localparam int LOSS_SHORT_CYC     = (LOSS_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOSS_LONG_CYC      = (LOSS_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOSS_CNT_W         = 12;     // Counter width for the delays.

  // ------------------------------------------------------------------
  // Standby state machine, Gray coded along RUN -> AUTO -> MANUAL.
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN          = 2'b00,  // Normal operation.
    ST_AUTO_SLEEP   = 2'b01,  // Standby entered on loss of cable energy.
    ST_MANUAL_SLEEP = 2'b11   // Standby commanded by the host; reset only.
  } sleep_state_t;

endpackage

// [hdl/energy_qualifier.sv]
// Synchroniser and loss-delay filter for the cable energy detector input.
`timescale 1ns/1ps
module energy_qualifier
  import deep_sleep_pkg::*;
(
  input  wire logic clk,             // System clock.
  input  wire logic rst_n,           // Asynchronous reset, active low.
  input  wire logic energy_raw,      // Cable energy detector, asynchronous.
  input  wire logic long_delay,      // Selects the increased loss delay.
  output logic      energy_q         // Qualified energy present.
);

  // ------------------------------------------------------------------
  // Two-flop synchroniser.
  // ------------------------------------------------------------------
  logic                  sync1_reg;  // First stage, read only by the second.
  logic                  sync2_reg;  // Safe synchronised level.
  logic [LOSS_CNT_W-1:0] loss_cnt_reg; // Cycles without energy.
  logic [LOSS_CNT_W-1:0] loss_limit;   // Selected loss delay.

  // The pin is sampled twice before anything looks at it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= energy_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // ------------------------------------------------------------------
  // Loss delay.
  // ------------------------------------------------------------------
  // The delay before energy is declared lost depends on the setting.
  assign loss_limit = long_delay ? LOSS_CNT_W'(LOSS_LONG_CYC) : LOSS_CNT_W'(LOSS_SHORT_CYC);

  // Energy returns at once; loss is only declared after the delay ran out.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loss_cnt_reg <= '0;
      energy_q     <= 1'b0;
    end else if (sync2_reg) begin
      loss_cnt_reg <= '0;
      energy_q     <= 1'b1;
    end else if (loss_cnt_reg >= loss_limit - 1'b1) begin
      energy_q     <= 1'b0;
    end else begin
      loss_cnt_reg <= loss_cnt_reg + 1'b1;
    end
  end

  // Energy seen by the synchroniser is reported on the next edge.
  AST_ENERGY_RISE: assert property (@(posedge clk) disable iff (!rst_n)
    sync2_reg |=> energy_q) else $error("Energy not reported after synchroniser.");

  // A single absent sample never drops the indication.
  AST_ENERGY_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (sync2_reg ##1 !sync2_reg) |=> energy_q) else $error("Energy dropped without delay.");

endmodule

// [hdl/phy_deep_sleep_control.sv]
// Low-power, slow-oscillator and deepest-standby control registers.
`timescale 1ns/1ps

module phy_deep_sleep_control
  import deep_sleep_pkg::*;
(
  input  wire logic        clk,                     // 50 MHz system clock.
  input  wire logic        rst_n,                   // Hardware reset, active low.
  input  wire logic        por_n,                   // Power-on reset of retained copy.
  input  wire logic        mgmt_req,                // Register access strobe.
  input  wire logic        mgmt_wr,                 // 1 = write, 0 = read.
  input  wire logic [4:0]  mgmt_addr,               // Register number.
  input  wire logic [15:0] mgmt_wdata,              // Write data.
  input  wire logic        power_down,              // Power-down request level.
  input  wire logic        cable_energy_raw,        // Cable energy detector pin.
  output logic [15:0]      mgmt_rdata,              // Read data.
  output logic             mgmt_rvalid,             // Read data valid, one cycle.
  output logic             slow_osc_select,         // 1 = run from slow oscillator.
  output logic             detector_high_en,        // High threshold comparator on.
  output logic             deep_sleep,              // Deepest standby active.
  output logic             cable_energy_indication, // Energy output pin level.
  output logic             rx_term_disable,         // Receive termination off.
  output logic             shadow_active            // Retained copy in use.
);

  // ------------------------------------------------------------------
  // Storage.
  // ------------------------------------------------------------------
  logic [15:0]  afe_zero_reg;      // Front-end control zero.
  logic [15:0]  afe_two_reg;       // Front-end control two.
  afe_three_t   afe_three_reg;     // Front-end control three.
  logic [15:0]  shadow_two_reg;    // Retained bits of control two.
  afe_three_t   shadow_three_reg;  // Retained copy of control three.
  logic         shadow_valid_reg;  // Retained copy has been written.
  logic         restore_pend_reg;  // Restore due after reset release.
  sleep_state_t state_reg;         // Standby state.
  sleep_state_t state_next;        // Next standby state.
  logic         energy_q;          // Qualified cable energy.
  logic         access_ok;         // Register access currently served.
  logic         wr_two;            // Write to control two.
  logic         wr_three;          // Write to control three.

  // Decodes a register number against one register address.
  function automatic logic hit(input logic [4:0] a, input logic [4:0] base);
    hit = (a == base);
  endfunction

  // ------------------------------------------------------------------
  // Energy input conditioning.
  // ------------------------------------------------------------------
  energy_qualifier u_energy (
    .clk        (clk),
    .rst_n      (rst_n),
    .energy_raw (cable_energy_raw),
    .long_delay (afe_three_reg.long_loss_delay),
    .energy_q   (energy_q)
  );

  // ------------------------------------------------------------------
  // Register access.
  // ------------------------------------------------------------------
  // In standby the fast clock is gone; access survives only on the slow one.
  assign access_ok = (state_reg == ST_RUN) || afe_two_reg[UDS_SLOW_OSC_BIT];
  assign wr_two    = mgmt_req && mgmt_wr && access_ok && hit(mgmt_addr, ADDR_AFE_TWO);
  assign wr_three  = mgmt_req && mgmt_wr && access_ok && hit(mgmt_addr, ADDR_AFE_THREE);

  // Writes store whole words; after reset a valid retained copy with its shadow enable set is reloaded.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      afe_zero_reg  <= AFE_ZERO_RST;
      afe_two_reg   <= AFE_TWO_RST;
      afe_three_reg <= afe_three_t'(AFE_THREE_RST);
    end else if (restore_pend_reg) begin
      // Restore the retained settings once, at the first edge after reset.
      if (shadow_valid_reg && shadow_three_reg.nonvolatile_shadow_enable) begin
        afe_two_reg   <= (afe_two_reg & ~AFE_TWO_NV_MASK) | (shadow_two_reg & AFE_TWO_NV_MASK);
        afe_three_reg <= shadow_three_reg;
      end
    end else if (mgmt_req && mgmt_wr && access_ok) begin
      if (hit(mgmt_addr, ADDR_AFE_ZERO)) begin
        afe_zero_reg <= mgmt_wdata;
      end
      if (wr_two) begin
        afe_two_reg <= mgmt_wdata;
      end
      if (wr_three) begin
        afe_three_reg <= afe_three_t'(mgmt_wdata);
      end
    end
  end

  // Restore is pending for exactly one edge after each reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      restore_pend_reg <= 1'b1;
    end else begin
      restore_pend_reg <= 1'b0;
    end
  end

  // Read data returns on the edge after the strobe; other numbers read zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mgmt_rdata  <= 16'h0000;
      mgmt_rvalid <= 1'b0;
    end else begin
      mgmt_rvalid <= mgmt_req && !mgmt_wr && access_ok;
      if (mgmt_req && !mgmt_wr && access_ok) begin
        if (hit(mgmt_addr, ADDR_AFE_ZERO)) begin
          mgmt_rdata <= afe_zero_reg;
        end else if (hit(mgmt_addr, ADDR_AFE_TWO)) begin
          mgmt_rdata <= afe_two_reg;
        end else if (hit(mgmt_addr, ADDR_AFE_THREE)) begin
          mgmt_rdata <= afe_three_reg;
        end else begin
          mgmt_rdata <= 16'h0000;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Retained copy, kept across hardware reset, cleared at power-on.
  // ------------------------------------------------------------------
  // Control two writes are mirrored while the shadow is enabled in control three; control three writes always are.
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      shadow_two_reg   <= AFE_TWO_RST;
      shadow_three_reg <= afe_three_t'(AFE_THREE_RST);
      shadow_valid_reg <= 1'b0;
    end else if (!restore_pend_reg) begin
      if (wr_two && afe_three_reg.nonvolatile_shadow_enable) begin
        shadow_two_reg <= mgmt_wdata & AFE_TWO_NV_MASK;
      end
      if (wr_three) begin
        // Disabling the copy is itself retained so a reset will not reload it.
        shadow_three_reg <= afe_three_t'(mgmt_wdata);
        shadow_valid_reg <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Standby state machine.
  // ------------------------------------------------------------------
  // Chooses entry by method; manual standby is left only through reset.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (afe_three_reg.sleep_enable && !restore_pend_reg) begin
          if (afe_three_reg.method_manual) begin
            if (afe_three_reg.manual_sleep) begin
              state_next = ST_MANUAL_SLEEP;
            end
          end else if (!energy_q) begin
            state_next = ST_AUTO_SLEEP;
          end
        end
      end
      ST_AUTO_SLEEP: begin
        // Energy return, a method change or disabling standby wakes it.
        if (energy_q || !afe_three_reg.sleep_enable || afe_three_reg.method_manual) begin
          state_next = ST_RUN;
        end
      end
      ST_MANUAL_SLEEP: begin
        state_next = ST_MANUAL_SLEEP;
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  // State register; only the hardware reset returns from manual standby to normal operation.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs, all registered.
  // ------------------------------------------------------------------
  // Clock selection, standby flag and front-end controls.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_osc_select  <= 1'b0;
      detector_high_en <= 1'b0;
      deep_sleep       <= 1'b0;
      rx_term_disable  <= 1'b0;
      shadow_active    <= 1'b0;
    end else begin
      slow_osc_select  <= (afe_zero_reg[PD_SLOW_OSC_BIT] && power_down)
                        || (afe_two_reg[UDS_SLOW_OSC_BIT] && (state_next != ST_RUN));
      detector_high_en <= afe_two_reg[DET_THRESH_BIT];
      deep_sleep       <= (state_next != ST_RUN);
      rx_term_disable  <= afe_three_reg.rx_term_disable;
      shadow_active    <= afe_three_reg.nonvolatile_shadow_enable;
    end
  end

  // Energy indication: forced true while standby is disabled.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cable_energy_indication <= 1'b1;
    end else if (!afe_three_reg.sleep_enable) begin
      cable_energy_indication <= !afe_three_reg.indication_low;
    end else begin
      cable_energy_indication <= energy_q ^ afe_three_reg.indication_low;
    end
  end

  // ------------------------------------------------------------------
  // Checks.
  // ------------------------------------------------------------------
  sequence s_manual_cmd;
    afe_three_reg.sleep_enable && afe_three_reg.method_manual && afe_three_reg.manual_sleep
      && state_reg == ST_RUN && !restore_pend_reg;
  endsequence

  sequence s_auto_loss;
    afe_three_reg.sleep_enable && !afe_three_reg.method_manual && !energy_q
      && state_reg == ST_RUN && !restore_pend_reg;
  endsequence

  AST_MANUAL_ENTRY: assert property (@(posedge clk) disable iff (!rst_n)
    s_manual_cmd |=> deep_sleep ##0 state_reg == ST_MANUAL_SLEEP) else $error("Manual standby not entered.");

  AST_MANUAL_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == ST_MANUAL_SLEEP |=> (deep_sleep && state_reg == ST_MANUAL_SLEEP) [*3])
    else $error("Manual standby left without reset.");

  AST_AUTO_ENTRY: assert property (@(posedge clk) disable iff (!rst_n)
    s_auto_loss |=> deep_sleep) else $error("Automatic standby not entered.");

  AST_METHOD_MANUAL: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_RUN && afe_three_reg.method_manual && !afe_three_reg.manual_sleep) |=> !deep_sleep)
    else $error("Standby entered without manual command.");

  AST_DISABLED: assert property (@(posedge clk) disable iff (!rst_n)
    (!afe_three_reg.sleep_enable && state_reg != ST_MANUAL_SLEEP) |=> !deep_sleep
      ##0 cable_energy_indication == !$past(afe_three_reg.indication_low))
    else $error("Disabled standby not honoured.");

  AST_THRESHOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_two && !restore_pend_reg) |-> ##2 detector_high_en == $past(mgmt_wdata[DET_THRESH_BIT], 2))
    else $error("Threshold comparator does not follow write.");

  AST_PD_OSC: assert property (@(posedge clk) disable iff (!rst_n)
    (afe_zero_reg[PD_SLOW_OSC_BIT] && power_down) |=> slow_osc_select)
    else $error("Slow oscillator not selected in power down.");

  AST_UDS_ACCESS: assert property (@(posedge clk) disable iff (!rst_n)
    (mgmt_req && !mgmt_wr && state_reg != ST_RUN) |=> mgmt_rvalid == $past(afe_two_reg[UDS_SLOW_OSC_BIT]))
    else $error("Standby register access wrong.");

endmodule

// [verification/mgmt_host_model.sv]
// Host side of the management register port, with read and write tasks.
`timescale 1ns/1ps
module mgmt_host_model (
  input  wire logic        clk,         // System clock.
  output logic             mgmt_req,    // Access strobe.
  output logic             mgmt_wr,     // 1 = write.
  output logic [4:0]       mgmt_addr,   // Register number.
  output logic [15:0]      mgmt_wdata,  // Write data.
  input  wire logic        mgmt_rvalid, // Read data valid.
  input  wire logic [15:0] mgmt_rdata   // Read data.
);
  // Idle values; the address goes to an unused pattern when released.
  initial begin
    mgmt_req   = 1'b0;
    mgmt_wr    = 1'b0;
    mgmt_addr  = 5'h1f;
    mgmt_wdata = 16'hffff;
  end

  // One write: strobe for one cycle, everything held until the taking edge.
  // Callers keep reserved bits zero except where storage itself is probed.
  task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    mgmt_req   <= 1'b1;
    mgmt_wr    <= 1'b1;
    mgmt_addr  <= a;
    mgmt_wdata <= d;
    @(posedge clk);
    mgmt_req   <= 1'b0;
    mgmt_addr  <= ~a;
    mgmt_wdata <= ~d;
  endtask

  // One read: the answer stands for the single cycle after the taking edge.
  task automatic read_reg(input logic [4:0] a, output logic [15:0] d, output logic v);
    @(posedge clk);
    mgmt_req  <= 1'b1;
    mgmt_wr   <= 1'b0;
    mgmt_addr <= a;
    @(posedge clk);
    mgmt_req  <= 1'b0;
    mgmt_addr <= ~a;
    #1;
    v = mgmt_rvalid;
    d = mgmt_rdata;
  endtask
endmodule

// [verification/phy_deep_sleep_control_tb.sv]
// Self-checking testbench of the deepest-standby control registers.
`timescale 1ns/1ps
module phy_deep_sleep_control_tb;
  import deep_sleep_pkg::*;

  // ------------------------------------------------------------------
  // Signals and counters.
  // ------------------------------------------------------------------
  logic        clk, rst_n, por_n, power_down, cable_energy_raw;
  logic        mgmt_req, mgmt_wr, mgmt_rvalid;
  logic [4:0]  mgmt_addr;
  logic [15:0] mgmt_wdata, mgmt_rdata, rd;
  logic        slow_osc_select, detector_high_en, deep_sleep;
  logic        cable_energy_indication, rx_term_disable, shadow_active, rv;
  int          bad_count, checks_done, cycles;

  mgmt_host_model host (.clk(clk), .mgmt_req(mgmt_req), .mgmt_wr(mgmt_wr), .mgmt_addr(mgmt_addr),
    .mgmt_wdata(mgmt_wdata), .mgmt_rvalid(mgmt_rvalid), .mgmt_rdata(mgmt_rdata));

  phy_deep_sleep_control dut (.clk(clk), .rst_n(rst_n), .por_n(por_n), .mgmt_req(mgmt_req),
    .mgmt_wr(mgmt_wr), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .power_down(power_down),
    .cable_energy_raw(cable_energy_raw), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
    .slow_osc_select(slow_osc_select), .detector_high_en(detector_high_en), .deep_sleep(deep_sleep),
    .cable_energy_indication(cable_energy_indication), .rx_term_disable(rx_term_disable),
    .shadow_active(shadow_active));

  // ------------------------------------------------------------------
  // Clock, timeout and helper tasks.
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // A hung run counts as a mismatch and closes the report.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  // Compares a seen value with the expected one and counts the outcome.
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Reads a register and compares both the valid flag and the data.
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    host.read_reg(a, rd, rv);
    chk("read valid", {15'h0000, rv}, 16'h0001);
    chk("read data", rd, exp);
  endtask

  // Waits n edges, then lets the updates of the last edge settle.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Hardware reset, optionally with power-on reset of the retained copy.
  task automatic do_reset(input logic por);
    @(posedge clk);
    rst_n <= 1'b0;
    por_n <= ~por;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    cyc(2);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------------
  initial begin
    rst_n = 1'b0; por_n = 1'b0; power_down = 1'b0; cable_energy_raw = 1'b1;
    bad_count = 0; checks_done = 0; cycles = 0;
    do_reset(1'b1);
    chk("indication at reset", {15'h0, cable_energy_indication}, 16'h0001);
    rd_chk(ADDR_AFE_THREE, AFE_THREE_RST);
    rd_chk(ADDR_AFE_TWO, AFE_TWO_RST);
    // Reserved bits store writes; unmapped numbers read zero.
    host.write_reg(ADDR_AFE_ZERO, 16'hffff);
    rd_chk(ADDR_AFE_ZERO, 16'hffff);
    host.write_reg(5'h12, 16'h5a5a);
    rd_chk(5'h12, 16'h0000);
    // Slow oscillator only while powered down.
    cyc(3);
    chk("slow osc idle", {15'h0, slow_osc_select}, 16'h0000);
    @(posedge clk) power_down <= 1'b1;
    cyc(3);
    chk("slow osc power down", {15'h0, slow_osc_select}, 16'h0001);
    @(posedge clk) power_down <= 1'b0;
    // High threshold chosen for the large pulse, then low again.
    host.write_reg(ADDR_AFE_TWO, 16'h8000);
    cyc(2);
    chk("threshold high", {15'h0, detector_high_en}, 16'h0001);
    host.write_reg(ADDR_AFE_TWO, 16'h0000);
    cyc(2);
    chk("threshold low", {15'h0, detector_high_en}, 16'h0000);
    // Standby disabled forces the indication true, checked here in the active-low polarity.
    host.write_reg(ADDR_AFE_THREE, 16'h0001);
    cyc(2);
    chk("forced low polarity", {15'h0, cable_energy_indication}, 16'h0000);
    host.write_reg(ADDR_AFE_THREE, 16'h001d);
    cyc(4);
    chk("rx termination", {15'h0, rx_term_disable}, 16'h0001);
    chk("energy active low", {15'h0, cable_energy_indication}, 16'h0000);
    // Host method with manual bit clear: energy loss brings no standby.
    host.write_reg(ADDR_AFE_THREE, 16'h0058);
    cable_energy_raw <= 1'b0;
    cyc(150);
    chk("no standby manual clear", {15'h0, deep_sleep}, 16'h0000);
    chk("energy lost shown", {15'h0, cable_energy_indication}, 16'h0000);
    @(posedge clk) cable_energy_raw <= 1'b1;
    host.write_reg(ADDR_AFE_TWO, 16'h8301);
    host.write_reg(ADDR_AFE_THREE, 16'h0078);
    cyc(2);
    chk("manual standby", {15'h0, deep_sleep}, 16'h0001);
    chk("standby slow osc", {15'h0, slow_osc_select}, 16'h0001);
    rd_chk(ADDR_AFE_THREE, 16'h0078);
    host.write_reg(ADDR_AFE_THREE, 16'h0058);
    cyc(20);
    chk("manual standby held", {15'h0, deep_sleep}, 16'h0001);
    // Hardware reset leaves standby and reloads the retained copy.
    do_reset(1'b0);
    chk("awake after reset", {15'h0, deep_sleep}, 16'h0000);
    chk("shadow restored", {15'h0, shadow_active}, 16'h0001);
    rd_chk(ADDR_AFE_THREE, 16'h0058);
    rd_chk(ADDR_AFE_TWO, 16'h0301);
    rd_chk(ADDR_AFE_ZERO, AFE_ZERO_RST);
    // A cleared shadow enable is retained, so the next reset reloads nothing.
    host.write_reg(ADDR_AFE_THREE, 16'h0004);
    do_reset(1'b0);
    rd_chk(ADDR_AFE_THREE, AFE_THREE_RST);
    rd_chk(ADDR_AFE_TWO, AFE_TWO_RST);
    do_reset(1'b1);
    rd_chk(ADDR_AFE_THREE, AFE_THREE_RST);
    // The long loss delay keeps the link awake well past the short delay.
    host.write_reg(ADDR_AFE_THREE, 16'h001a);
    cable_energy_raw <= 1'b0;
    cyc(150);
    chk("long delay awake", {15'h0, deep_sleep}, 16'h0000);
    // Automatic method: standby on energy loss, registers refused inside.
    host.write_reg(ADDR_AFE_THREE, 16'h0018);
    for (int i = 0; i < 200 && deep_sleep !== 1'b1; i++) cyc(1);
    chk("auto standby", {15'h0, deep_sleep}, 16'h0001);
    host.read_reg(ADDR_AFE_THREE, rd, rv);
    chk("refused read", {15'h0, rv}, 16'h0000);
    @(posedge clk) cable_energy_raw <= 1'b1;
    cyc(10);
    chk("auto wake", {15'h0, deep_sleep}, 16'h0000);
    complete_run();
  end
endmodule
